// ---- sector_pulse_map.vh ----
/*
 Constants for the sector pulse generator: counter limits, clock rates,
 pulse timing and the sector-address command code.
 Assumes a 200 MHz system clock; included by bare name.
*/
`ifndef SECTOR_PULSE_MAP_VH
`define SECTOR_PULSE_MAP_VH

// System clock period in picoseconds (200 MHz)
`define SYS_CLK_PERIOD_PS       5000
// Sector counter width and its terminal count
`define SECTOR_CNT_WIDTH        12
`define SECTOR_CNT_MAX          12'hFFF
// Counting clocks per revolution for each variant
`define REV_CLOCKS_LOW          13440
`define REV_CLOCKS_HIGH         26880
// Counting clock rates in kHz
`define COUNT_CLK_LOW_KHZ       806
`define COUNT_CLK_HIGH_KHZ      1612
// Sector pulse width in nanoseconds
`define SECTOR_PULSE_NS         1250
// Index pulse width in nanoseconds
`define INDEX_PULSE_NS          2500
// Sector pulse width in system clocks, rounded up
`define SECTOR_PULSE_CYCLES \
    ((`SECTOR_PULSE_NS * 1000 + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS)
// Sector address width and command code on the tag lines
`define SECTOR_ADDR_WIDTH       8
`define TAG_SECTOR_ADDR         4'h4
`define TAG_WIDTH               4

`endif

// ---- pulse_stretcher.v ----
/*
 Fixed-width pulse former: a one-cycle trigger starts a high output that
 lasts WIDTH system clocks. A trigger during the pulse restarts it.
 Assumes trigger is synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pulse_stretcher #(
    parameter WIDTH = 250,
    parameter CW    = 9
)(
    // Clock and reset
    input  wire          clock,
    input  wire          rst_n,
    input  wire          clk_en,
    // Trigger and output
    input  wire          trigger,
    output reg           pulse_q
);

    reg [CW-1:0] count_q;

    // Down counter times the pulse; replaces an analogue one-shot
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= {CW{1'b0}};
            pulse_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (trigger)
            begin
                count_q <= WIDTH[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
                pulse_q <= 1'b1;
            end
            else if (count_q != {CW{1'b0}})
            begin
                count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
            end
            else
            begin
                pulse_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- sector_pulse_generator.v ----
/*
 Sector pulse generator: divides each revolution into sectors using a
 presettable 12-bit counter driven by the servo-derived counting clock,
 forms timed sector pulses, and keeps a current-sector count that is
 returned to the controller on the sector-address tag.
 Assumes count clock, index, tag strobe and switches are asynchronous pins
 that toggle far slower than the 200 MHz system clock.
*/
// Operation
// - Low-rate variant advances sector counter on each 806 kHz counting clock.
// - High-rate variant advances on each 1.612 MHz clock; 26880 per revolution.
// - Index resets sector counter; low rate gives 13440 clocks per revolution.
// - Counter reaching 4095 gives a carry ending the sector.
// - Each carry becomes one sector pulse of 1.25 us.
// - Clock after 4095 reloads the preset, not zero.
// - Preset comes from sector-length switch inputs.
// - Current-sector counter clears on index, increments on each sector pulse.
// - Tag 4 places the 8-bit current sector on bus in bits 0-7.
// - Index pulse from the sync decoder is the sector counter reset.
// - Index is asserted 2.5 us per recognised index pattern; index_out_q instead copies the synchronised index_in at its own width.
`timescale 1ns/1ps
`default_nettype none
`include "sector_pulse_map.vh"

module sector_pulse_generator #(
    parameter CNT_W   = `SECTOR_CNT_WIDTH,
    parameter ADDR_W  = `SECTOR_ADDR_WIDTH,
    parameter PULSE_W = `SECTOR_PULSE_CYCLES
)(
    // Clock and reset
    input  wire              clock,
    input  wire              rst_n,
    input  wire              clk_en,
    // Servo timing inputs (asynchronous pins)
    input  wire              count_clk,
    input  wire              index_in,
    // Configuration
    input  wire              rate_high,
    input  wire [CNT_W-1:0]  sector_switch,
    // Controller tag interface
    input  wire              tag_strobe,
    input  wire [3:0]        tag_code,
    // Outputs
    output reg  [7:0]        bus_in_q,
    output reg               bus_in_valid_q,
    output reg               sector_pulse_q,
    output reg               index_out_q,
    output reg               rate_high_q
);

    localparam [CNT_W-1:0] CNT_MAX = `SECTOR_CNT_MAX;

    // Two-flop synchronisers; the first stage feeds only the second
    reg        cclk_m_q, cclk_s_q, cclk_d_q;
    reg        idx_m_q, idx_s_q, idx_d_q;
    reg        tag_m_q, tag_s_q, tag_d_q;
    reg [3:0]  code_m_q, code_s_q;
    reg [CNT_W-1:0] sw_m_q, sw_s_q;
    reg        rate_m_q;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cclk_m_q <= 1'b0;
            cclk_s_q <= 1'b0;
            idx_m_q  <= 1'b0;
            idx_s_q  <= 1'b0;
            tag_m_q  <= 1'b0;
            tag_s_q  <= 1'b0;
            code_m_q <= 4'h0;
            code_s_q <= 4'h0;
            sw_m_q   <= {CNT_W{1'b0}};
            sw_s_q   <= {CNT_W{1'b0}};
            rate_m_q <= 1'b0;
        end
        else if (clk_en)
        begin
            cclk_m_q <= count_clk;
            cclk_s_q <= cclk_m_q;
            idx_m_q  <= index_in;
            idx_s_q  <= idx_m_q;
            tag_m_q  <= tag_strobe;
            tag_s_q  <= tag_m_q;
            code_m_q <= tag_code;
            code_s_q <= code_m_q;
            sw_m_q   <= sector_switch;
            sw_s_q   <= sw_m_q;
            rate_m_q <= rate_high;
        end
    end

    // Edge detect history on synchronised levels
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cclk_d_q <= 1'b0;
            idx_d_q  <= 1'b0;
            tag_d_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            cclk_d_q <= cclk_s_q;
            idx_d_q  <= idx_s_q;
            tag_d_q  <= tag_s_q;
        end
    end

    wire count_tick = cclk_s_q & ~cclk_d_q;
    wire index_rise = idx_s_q & ~idx_d_q;
    wire tag_rise   = tag_s_q & ~tag_d_q;

    // rate select is static; captured as a level for status
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rate_high_q <= 1'b0;
        else if (clk_en)
            rate_high_q <= rate_m_q;
    end

    // Sector counter; rate only changes how often count_tick arrives
    reg [CNT_W-1:0] sector_cnt_q;
    reg             carry_q;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sector_cnt_q <= {CNT_W{1'b0}};
            carry_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            carry_q <= 1'b0;
            // index resets the counter to the preset
            if (index_rise)
                sector_cnt_q <= sw_s_q;
            else if (count_tick)
            begin
                if (sector_cnt_q == CNT_MAX)
                    sector_cnt_q <= sw_s_q;
                else
                begin
                    sector_cnt_q <= sector_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (sector_cnt_q == CNT_MAX - {{(CNT_W-1){1'b0}}, 1'b1})
                        carry_q <= 1'b1;
                end
            end
        end
    end

    // carry forms a 1.25 us pulse timed in system clocks
    wire sector_pulse_w;

    pulse_stretcher #(
        .WIDTH (PULSE_W),
        .CW    (9)
    ) u_sector_pulse (
        .clock   (clock),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .trigger (carry_q),
        .pulse_q (sector_pulse_w)
    );

    // Register the pulse and index for clean outputs
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sector_pulse_q <= 1'b0;
            index_out_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            sector_pulse_q <= sector_pulse_w;
            // index passes through at its own width
            index_out_q    <= idx_s_q;
        end
    end

    // Current-sector counter; index wins over a coincident carry
    reg [ADDR_W-1:0] cur_sector_q;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cur_sector_q <= {ADDR_W{1'b0}};
        else if (clk_en)
        begin
            // clear on index, count sector pulses
            if (index_rise)
                cur_sector_q <= {ADDR_W{1'b0}};
            else if (carry_q)
                cur_sector_q <= cur_sector_q + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
    end

    // Tag answer; bus stays valid while the tag strobe is high
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_in_q       <= 8'h00;
            bus_in_valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // sector address on bus in for tag 4
            if (tag_rise && code_s_q == `TAG_SECTOR_ADDR)
            begin
                bus_in_q       <= cur_sector_q[7:0];
                bus_in_valid_q <= 1'b1;
            end
            else if (!tag_s_q)
            begin
                bus_in_q       <= 8'h00;
                bus_in_valid_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- sector_pulse_generator_sva.sv ----
/* Port checker for the sector pulse generator.
   Assumes PULSE_W equals the bound instance's value. */
`timescale 1ns/1ps
`default_nettype none
module sector_pulse_generator_sva #(
    parameter PULSE_W = 250
)(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       count_clk,
    input wire logic       index_in,
    input wire logic       rate_high,
    input wire logic       tag_strobe,
    input wire logic [3:0] tag_code,
    input wire logic [7:0] bus_in_q,
    input wire logic       bus_in_valid_q,
    input wire logic       sector_pulse_q,
    input wire logic       index_out_q,
    input wire logic       rate_high_q
);
    logic [9:0] run_q;
    logic [3:0] since_q;
    logic       cc_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Pulse length, and clocks since the last count edge (saturates)
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q   <= 10'h000;
            since_q <= 4'hF;
            cc_q    <= 1'b0;
        end
        else
        begin
            run_q   <= sector_pulse_q ? run_q + 10'h001 : 10'h000;
            cc_q    <= count_clk;
            since_q <= (count_clk && !cc_q) ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
        end
    end
    AST_PULSE_WIDTH: assert property ($fell(sector_pulse_q) |-> run_q == PULSE_W)
        else $error("sector pulse width wrong");
    // Named bodies keep the labelled lines short
    property p_from_count;
        $rose(sector_pulse_q) |-> since_q inside {[4:8]};
    endproperty
    property p_tag_answer;
        $rose(tag_strobe) && tag_code == 4'h4 |-> ##[3:5] bus_in_valid_q;
    endproperty
    property p_tag_refuse;
        $rose(tag_strobe) && tag_code != 4'h4 |-> !bus_in_valid_q [*6];
    endproperty
    property p_answer_stable;
        bus_in_valid_q && $past(bus_in_valid_q) |-> $stable(bus_in_q);
    endproperty
    AST_PULSE_FROM_COUNT: assert property (p_from_count)
        else $error("sector pulse not tied to a count edge");
    AST_TAG_ANSWER: assert property (p_tag_answer)
        else $error("no answer to sector request");
    AST_TAG_REFUSE: assert property (p_tag_refuse)
        else $error("answer to another tag code");
    AST_BUS_IDLE: assert property (!bus_in_valid_q |-> bus_in_q == 8'h00)
        else $error("bus in not zero while idle");
    AST_ANSWER_DROP: assert property ($fell(tag_strobe) |-> ##[2:5] !bus_in_valid_q)
        else $error("answer outlives strobe");
    AST_ANSWER_STABLE: assert property (p_answer_stable)
        else $error("answer changed while standing");
    AST_INDEX_COPY: assert property ($rose(index_in) |-> ##[1:4] index_out_q)
        else $error("index not passed on");
    AST_RATE_COPY: assert property ($rose(rate_high) |-> ##[1:4] rate_high_q)
        else $error("rate select not passed on");
    COV_PULSE: cover property ($rose(sector_pulse_q));
    COV_ANSWER: cover property ($rose(bus_in_valid_q));
    COV_INDEX: cover property ($rose(index_out_q));
endmodule
bind sector_pulse_generator sector_pulse_generator_sva #(.PULSE_W(PULSE_W)) u_sva (
    .clock(clock), .rst_n(rst_n), .count_clk(count_clk), .index_in(index_in),
    .rate_high(rate_high), .tag_strobe(tag_strobe), .tag_code(tag_code),
    .bus_in_q(bus_in_q), .bus_in_valid_q(bus_in_valid_q), .sector_pulse_q(sector_pulse_q),
    .index_out_q(index_out_q), .rate_high_q(rate_high_q));
`default_nettype wire

// ---- tag_controller_model.sv ----
/* Controller model: issues tag commands and reads bus in.
   Assumes one clock shared with the drive. */
`timescale 1ns/1ps
`default_nettype none
module tag_controller_model (
    // Clock
    input  wire logic       clock,
    // Tag lines and answer
    output var  logic       tag_strobe,
    output var  logic [3:0] tag_code,
    input  wire logic [7:0] bus_in_q,
    input  wire logic       bus_in_valid_q
);
    initial
    begin
        tag_strobe = 1'b0;
        tag_code   = 4'h0;
    end
    task automatic ask(input logic [3:0] code, output logic [7:0] data, output logic seen);
        integer i;
        begin
            seen = 1'b0;
            data = 8'h00;
            @(posedge clock) tag_code <= code;
            repeat (4) @(posedge clock);
            tag_strobe <= 1'b1;
            for (i = 0; i < 8; i++)
            begin
                @(posedge clock);
                if (bus_in_valid_q === 1'b1 && !seen)
                begin
                    seen = 1'b1;
                    data = bus_in_q;
                end
            end
            tag_strobe <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// ---- sector_pulse_generator_tb.sv ----
/* Testbench for the sector pulse generator.
   Assumes the controller model sits on the tag lines. */
`timescale 1ns/1ps
`default_nettype none
module sector_pulse_generator_tb;
    logic        clock, rst_n, count_clk, index_in, rate_high, tag_strobe, seen;
    logic        bus_in_valid_q, sector_pulse_q, index_out_q, rate_high_q;
    logic [11:0] sector_switch;
    logic [3:0]  tag_code;
    logic [7:0]  bus_in_q, data;
    integer      mismatches, compares, pulses, width, run, p0, i;
    sector_pulse_generator #(.PULSE_W(4)) u_dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .count_clk(count_clk), .index_in(index_in), .rate_high(rate_high),
        .sector_switch(sector_switch), .tag_strobe(tag_strobe), .tag_code(tag_code),
        .bus_in_q(bus_in_q), .bus_in_valid_q(bus_in_valid_q), .sector_pulse_q(sector_pulse_q),
        .index_out_q(index_out_q), .rate_high_q(rate_high_q));
    tag_controller_model u_ctl (.clock(clock), .tag_strobe(tag_strobe), .tag_code(tag_code),
        .bus_in_q(bus_in_q), .bus_in_valid_q(bus_in_valid_q));
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Count sector pulses and keep the last one's length
    always @(posedge clock)
    begin
        if (sector_pulse_q === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            pulses <= pulses + 1;
            width  <= run;
            run    <= 0;
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Counting edges slow enough for the input synchronisers
    task automatic tick(input integer n, input integer half);
        repeat (n)
        begin
            @(posedge clock) count_clk <= 1'b1;
            repeat (half) @(posedge clock);
            count_clk <= 1'b0;
            repeat (half - 1) @(posedge clock);
        end
    endtask
    task automatic index_pulse();
        @(posedge clock) index_in <= 1'b1;
        repeat (10) @(posedge clock);
        check(index_out_q, 1);
        repeat (490) @(posedge clock);
        index_in <= 1'b0;
        repeat (10) @(posedge clock);
    endtask
    // Four clocks per sector after a shorter first one
    task automatic test_sectors();
        sector_switch <= 12'hFFC;
        index_pulse();
        p0 = pulses;
        tick(11, 5);
        repeat (20) @(posedge clock);
        check(12'(pulses - p0), 3);
        check(12'(width), 4);
        u_ctl.ask(4'h4, data, seen);
        check(seen, 1);
        check(data, 3);
    endtask
    // Index right after a sector end (counter at 4095) must restart from the new preset
    task automatic test_index_restart();
        sector_switch <= 12'hFFE;
        index_pulse();
        p0 = pulses;
        tick(5, 5);
        repeat (20) @(posedge clock);
        check(12'(pulses - p0), 3);
        u_ctl.ask(4'h4, data, seen);
        check(data, 3);
    endtask
    // High-rate variant: edges every 6 clocks instead of 10, sector length unchanged
    task automatic test_high_rate();
        sector_switch <= 12'hFFC;
        index_pulse();
        p0 = pulses;
        tick(8, 3);
        repeat (20) @(posedge clock);
        check(12'(pulses - p0), 2);
        u_ctl.ask(4'h4, data, seen);
        check(data, 2);
    endtask
    // Every other code goes unanswered
    task automatic test_refused();
        for (i = 0; i < 16; i++)
            if (i != 4)
            begin
                u_ctl.ask(4'(i), data, seen);
                check(seen, 0);
            end
        @(posedge clock) rate_high <= 1'b1;
        repeat (6) @(posedge clock);
        check(rate_high_q, 1);
    endtask
    initial
    begin
        mismatches = 0;
        compares = 0;
        pulses = 0;
        width = 0;
        run = 0;
        rst_n = 1'b0;
        count_clk = 1'b0;
        index_in = 1'b0;
        rate_high = 1'b0;
        sector_switch = 12'hFFC;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (5) @(posedge clock);
        test_sectors();
        test_index_restart();
        test_refused();
        test_high_rate();
        give_verdict();
    end
    // Watchdog against a hang
    initial
    begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
